// ===== hdl/hardware_return_stack.sv
// Functional notes
// - Sixteen entries of fifteen bits, apart from program and data space.
// - Calls, computed calls and interrupt vectoring push the program counter.
// - Return, return-with-literal and return-from-interrupt pop the stack.
// - Push and pop never change the program counter high latch.
// - With fault reset disabled, the stack wraps; push seventeen overwrites entry zero.
// - Overflow and underflow flags set regardless of fault reset enable.
// - Stack pointer is five bits wide to detect overflow and underflow.
// - Top-of-stack registers read and write the entry the pointer selects.
// - Push increments the pointer first, then writes the selected entry.
// - Pop reads the selected entry first, then decrements the pointer.
// - Empty is pointer 0x1F; first push selects entry zero.
// - With fault reset enabled, overflow or underflow requests a device reset.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module hardware_return_stack
    import return_stack_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sequencer side
    input wire stack_cmd_s stack_cmd,
    output stack_ret_s stack_ret,
    // Configuration word bit
    input wire logic stack_fault_reset_enable,
    // Towards reset-cause register and reset controller
    output stack_fault_s stack_fault,
    output logic irq
);

    // ------------------------------------------------------------
    // Storage and pointer
    // ------------------------------------------------------------
    logic [PC_W-1:0] entry_reg [DEPTH];
    logic [SP_W-1:0] stack_pointer_reg;
    logic [SP_W-1:0] stack_pointer_next;
    logic [IDX_W-1:0] cur_idx;
    logic [IDX_W-1:0] push_idx;
    logic push_op;
    logic pop_op;
    logic overflow_evt;
    logic underflow_evt;

    // Push wins when both arrive together
    assign push_op = stack_cmd.push;
    assign pop_op = stack_cmd.pop & ~stack_cmd.push;

    assign cur_idx = stack_pointer_reg[IDX_W-1:0];
    // Only the low four bits select an entry, so pointer 0x10 reuses entry 0
    assign push_idx = stack_pointer_next[IDX_W-1:0];

    assign overflow_evt = push_op & (stack_pointer_reg == SP_TOP);
    assign underflow_evt = pop_op & (stack_pointer_reg == SP_EMPTY);

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic apb_access;
    logic apb_hit;
    logic apb_write;
    logic apb_read;
    logic cpu_busy;
    logic wr_sp;
    logic wr_top_of_stack_low;
    logic wr_top_of_stack_high;
    logic wr_status;
    logic wr_mask;

    always_comb begin
        unique case (paddr)
            OFF_STACK_POINTER,
            OFF_TOS_LOW,
            OFF_TOS_HIGH,
            OFF_EVENT_STATUS,
            OFF_EVENT_MASK,
            OFF_STACK_STATE: apb_hit = 1'b1;
            default: apb_hit = 1'b0;
        endcase
    end

    // Stall software while the sequencer moves the stack, so neither is lost
    assign cpu_busy = push_op | pop_op;
    assign apb_access = psel & penable;
    assign pready = apb_access & ~cpu_busy;
    assign pslverr = pready & ~apb_hit;
    assign apb_write = pready & apb_hit & pwrite;
    assign apb_read = pready & apb_hit & ~pwrite;

    assign wr_sp = apb_write & (paddr == OFF_STACK_POINTER) & pstrb[0];
    assign wr_top_of_stack_low = apb_write & (paddr == OFF_TOS_LOW) & pstrb[0];
    assign wr_top_of_stack_high = apb_write & (paddr == OFF_TOS_HIGH) & pstrb[0];
    assign wr_status = apb_write & (paddr == OFF_EVENT_STATUS) & pstrb[0];
    assign wr_mask = apb_write & (paddr == OFF_EVENT_MASK) & pstrb[0];

    // ------------------------------------------------------------
    // Stack pointer
    // ------------------------------------------------------------
    always_comb begin
        stack_pointer_next = stack_pointer_reg;
        if (push_op) begin
            stack_pointer_next = stack_pointer_reg + SP_STEP;
        end else if (pop_op) begin
            stack_pointer_next = stack_pointer_reg - SP_STEP;
        end else if (wr_sp) begin
            stack_pointer_next = pwdata[SP_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_pointer_reg <= SP_EMPTY;
        end else begin
            stack_pointer_reg <= stack_pointer_next;
        end
    end

    // ------------------------------------------------------------
    // Entry storage
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            logic push_here;
            logic top_of_stack_low_here;
            logic top_of_stack_high_here;

            assign push_here = push_op & (push_idx == IDX_W'(gi));
            assign top_of_stack_low_here = wr_top_of_stack_low & (cur_idx == IDX_W'(gi));
            assign top_of_stack_high_here = wr_top_of_stack_high & (cur_idx == IDX_W'(gi));

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    entry_reg[gi] <= '0;
                end else if (push_here) begin
                    entry_reg[gi] <= stack_cmd.program_counter;
                end else if (top_of_stack_low_here) begin
                    entry_reg[gi][TOP_OF_STACK_LOW_W-1:0] <= pwdata[TOP_OF_STACK_LOW_W-1:0];
                end else if (top_of_stack_high_here) begin
                    entry_reg[gi][PC_W-1:TOP_OF_STACK_LOW_W] <= pwdata[TOP_OF_STACK_HIGH_W-1:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Return address towards the sequencer
    // ------------------------------------------------------------
    // Only the counter value is returned; the high latch has no path here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_ret <= '0;
        end else begin
            stack_ret.valid <= pop_op;
            if (pop_op) begin
                stack_ret.program_counter <= entry_reg[cur_idx];
            end
        end
    end

    // ------------------------------------------------------------
    // Fault signalling
    // ------------------------------------------------------------
    // Flags pulse into the external reset-cause register, which holds them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_fault <= '0;
        end else begin
            stack_fault.stack_overflow_flag <= overflow_evt;
            stack_fault.stack_underflow_flag <= underflow_evt;
            stack_fault.reset_request <= stack_fault_reset_enable
                & (overflow_evt | underflow_evt);
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic [EVT_W-1:0] event_status_reg;
    logic [EVT_W-1:0] event_mask_reg;
    logic [EVT_W-1:0] event_set;

    assign event_set[EVT_OVERFLOW] = overflow_evt;
    assign event_set[EVT_UNDERFLOW] = underflow_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_status_reg <= EVT_RESET;
        end else if (wr_status) begin
            // A new event in the clearing cycle stays set
            event_status_reg <= (event_status_reg & ~pwdata[EVT_W-1:0]) | event_set;
        end else begin
            event_status_reg <= event_status_reg | event_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_mask_reg <= EVT_RESET;
        end else if (wr_mask) begin
            event_mask_reg <= pwdata[EVT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(event_status_reg & event_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rdata_mux;
    logic [PC_W-1:0] tos_value;

    assign tos_value = entry_reg[cur_idx];

    always_comb begin
        rdata_mux = DATA_ZERO;
        unique case (paddr)
            OFF_STACK_POINTER: rdata_mux[SP_W-1:0] = stack_pointer_reg;
            OFF_TOS_LOW: rdata_mux[TOP_OF_STACK_LOW_W-1:0] = tos_value[TOP_OF_STACK_LOW_W-1:0];
            OFF_TOS_HIGH: rdata_mux[TOP_OF_STACK_HIGH_W-1:0] = tos_value[PC_W-1:TOP_OF_STACK_LOW_W];
            OFF_EVENT_STATUS: rdata_mux[EVT_W-1:0] = event_status_reg;
            OFF_EVENT_MASK: rdata_mux[EVT_W-1:0] = event_mask_reg;
            OFF_STACK_STATE: begin
                rdata_mux[ST_FAULT_RESET_EN] = stack_fault_reset_enable;
                rdata_mux[ST_EMPTY] = (stack_pointer_reg == SP_EMPTY);
                rdata_mux[ST_FULL] = (stack_pointer_reg == SP_TOP);
            end
            default: rdata_mux = DATA_ZERO;
        endcase
    end

    // Read data is captured at the setup edge and again at each stalled access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= DATA_ZERO;
        end else if (psel & ~pwrite & ~(penable & ~cpu_busy)) begin
            prdata <= rdata_mux;
        end else if (apb_read) begin
            prdata <= rdata_mux;
        end
    end

endmodule // hardware_return_stack

`default_nettype wire

// ===== hdl/return_stack_pkg.sv
package return_stack_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int DEPTH = 16;
    localparam int PC_W = 15;
    localparam int SP_W = 5;
    localparam int IDX_W = 4;
    localparam int TOP_OF_STACK_LOW_W = 8;
    localparam int TOP_OF_STACK_HIGH_W = 7;
    localparam int EVT_W = 2;

    // ------------------------------------------------------------
    // Stack pointer values
    // ------------------------------------------------------------
    localparam logic [SP_W-1:0] SP_EMPTY = 5'h1F;
    localparam logic [SP_W-1:0] SP_TOP = 5'h0F;
    localparam logic [SP_W-1:0] SP_STEP = 5'h01;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_STACK_POINTER = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_TOS_LOW = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_TOS_HIGH = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_EVENT_MASK = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_STACK_STATE = 12'h014;

    // Event bit positions, shared by status and mask
    localparam int EVT_OVERFLOW = 0;
    localparam int EVT_UNDERFLOW = 1;

    // Stack state register bit positions
    localparam int ST_FAULT_RESET_EN = 0;
    localparam int ST_EMPTY = 1;
    localparam int ST_FULL = 2;

    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic push;
        logic pop;
        logic [PC_W-1:0] program_counter;
    } stack_cmd_s;

    typedef struct packed {
        logic valid;
        logic [PC_W-1:0] program_counter;
    } stack_ret_s;

    typedef struct packed {
        logic stack_overflow_flag;
        logic stack_underflow_flag;
        logic reset_request;
    } stack_fault_s;

endpackage

// ===== test/return_stack_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module return_stack_assertions
    import return_stack_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire stack_cmd_s stack_cmd,
    input wire stack_ret_s stack_ret,
    input wire logic stack_fault_reset_enable,
    input wire stack_fault_s stack_fault
);
    // ------------------------------------------------------------
    // Stack and fault timing
    // ------------------------------------------------------------
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic pop_only;
    logic any_fault;
    assign pop_only = stack_cmd.pop && !stack_cmd.push;
    assign any_fault = stack_fault.stack_overflow_flag || stack_fault.stack_underflow_flag;
    AST_RET_ON_POP: assert property (pop_only |=> stack_ret.valid)
        else $error("pop gave no return");
    AST_RET_ONLY_POP: assert property (!pop_only |=> !stack_ret.valid)
        else $error("return without pop");
    AST_LIFO: assert property (stack_cmd.push ##1 pop_only |=>
        stack_ret.program_counter == $past(stack_cmd.program_counter, 2))
        else $error("pop did not return the last push");
    AST_OVF_CAUSE: assert property (stack_fault.stack_overflow_flag |-> $past(stack_cmd.push))
        else $error("overflow without push");
    AST_UNF_CAUSE: assert property (stack_fault.stack_underflow_flag |-> $past(pop_only))
        else $error("underflow without pop");
    AST_REQ_ON: assert property (any_fault && $past(stack_fault_reset_enable)
        |-> stack_fault.reset_request)
        else $error("fault gave no reset request");
    AST_REQ_OFF: assert property (stack_fault.reset_request
        |-> any_fault && $past(stack_fault_reset_enable))
        else $error("reset request without enabled fault");
    AST_FLAG_EXCL: assert property (!(stack_fault.stack_overflow_flag
        && stack_fault.stack_underflow_flag))
        else $error("both fault flags at once");
endmodule // return_stack_assertions

bind hardware_return_stack return_stack_assertions i_chk (.pclk(pclk), .presetn(presetn),
    .stack_cmd(stack_cmd), .stack_ret(stack_ret),
    .stack_fault_reset_enable(stack_fault_reset_enable), .stack_fault(stack_fault));
`default_nettype wire

// ===== test/sequencer_model.sv
`timescale 1ns/1ps
`default_nettype none
module sequencer_model
    import return_stack_pkg::*;
(
    input wire logic pclk,
    output var stack_cmd_s stack_cmd,
    input wire stack_ret_s stack_ret
);
    // ------------------------------------------------------------
    // Calls, interrupts and returns
    // ------------------------------------------------------------
    initial stack_cmd = '0;
    // Push stays up until the next operation, so pushes go back to back
    task automatic push(input logic [PC_W-1:0] pc);
        @(posedge pclk);
        stack_cmd <= '{push: 1'b1, pop: 1'b0, program_counter: pc};
    endtask
    task automatic idle();
        @(posedge pclk);
        stack_cmd <= '0;
    endtask
    task automatic pop(output logic [PC_W-1:0] pc, output logic got);
        got = 1'b0;
        pc = '0;
        @(posedge pclk);
        stack_cmd <= '{push: 1'b0, pop: 1'b1, program_counter: '0};
        @(posedge pclk);
        stack_cmd <= '0;
        for (int i = 0; i < 4 && !got; i++) begin
            @(posedge pclk);
            got = stack_ret.valid === 1'b1;
            pc = stack_ret.program_counter;
        end
    endtask
endmodule // sequencer_model
`default_nettype wire

// ===== test/test_hardware_return_stack.sv
`timescale 1ns/1ps
`default_nettype none
module test_hardware_return_stack
    import return_stack_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, fault_en, got, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [PC_W-1:0] pc;
    stack_cmd_s stack_cmd;
    stack_ret_s stack_ret;
    stack_fault_s stack_fault;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_req = 0;
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    hardware_return_stack i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .stack_cmd, .stack_ret,
        .stack_fault_reset_enable(fault_en), .stack_fault, .irq);
    sequencer_model i_seq (.pclk, .stack_cmd, .stack_ret);
    always @(posedge pclk)
        if (stack_fault.reset_request === 1'b1)
            n_req <= n_req + 1;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20) begin
            n_mismatch++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, DATA_ZERO);
        chk(rd, exp);
    endtask
    task automatic pop_chk(input logic [PC_W-1:0] exp);
        i_seq.pop(pc, got);
        chk(32'({got, pc}), 32'({1'b1, exp}));
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_call_return();
        rdc(OFF_STACK_POINTER, 32'h1F);
        rdc(OFF_STACK_STATE, 32'h2);
        i_seq.push(15'h1234);
        i_seq.idle();
        rdc(OFF_STACK_POINTER, 32'h0);
        rdc(OFF_TOS_LOW, 32'h34);
        rdc(OFF_TOS_HIGH, 32'h12);
        i_seq.push(15'h0ABC);
        pop_chk(15'h0ABC);
        pop_chk(15'h1234);
        rdc(OFF_STACK_POINTER, 32'h1F);
        rdc(OFF_EVENT_STATUS, 32'h0);
    endtask
    task automatic t_wrap();
        apb(1'b1, OFF_EVENT_MASK, 32'h3);
        for (int k = 0; k < 17; k++)
            i_seq.push(15'(k + 32'h100));
        i_seq.idle();
        rdc(OFF_STACK_POINTER, 32'h10);
        rdc(OFF_TOS_LOW, 32'h10);
        rdc(OFF_EVENT_STATUS, 32'h1);
        chk(32'(irq), 32'h1);
        apb(1'b1, OFF_EVENT_STATUS, 32'h1);
        rdc(OFF_EVENT_STATUS, 32'h0);
        chk(32'(irq), 32'h0);
        apb(1'b1, OFF_EVENT_MASK, 32'h0);
        apb(1'b1, OFF_STACK_POINTER, 32'h1F);
        pop_chk(15'h10F);
        rdc(OFF_EVENT_STATUS, 32'h2);
        chk(32'(irq), 32'h0);
        chk(n_req, 32'h0);
        apb(1'b1, OFF_EVENT_STATUS, 32'h2);
    endtask
    task automatic t_fault_reset();
        fault_en <= 1'b1;
        apb(1'b1, OFF_STACK_POINTER, 32'h0F);
        rdc(OFF_STACK_STATE, 32'h5);
        i_seq.push(15'h0001);
        i_seq.idle();
        // Request pulses one edge after the push and is counted one edge later
        repeat (2) @(posedge pclk);
        chk(n_req, 32'h1);
        apb(1'b1, OFF_STACK_POINTER, 32'h1F);
        i_seq.pop(pc, got);
        repeat (2) @(posedge pclk);
        chk(n_req, 32'h2);
        rdc(OFF_EVENT_STATUS, 32'h3);
        fault_en <= 1'b0;
    endtask
    task automatic t_tos_write();
        apb(1'b1, OFF_STACK_POINTER, 32'h3);
        apb(1'b1, OFF_TOS_LOW, 32'hA5);
        pstrb <= 4'hE;
        apb(1'b1, OFF_TOS_HIGH, 32'h7F);
        pstrb <= 4'hF;
        // Entry 3 still holds the wrap scenario's push; a write without pstrb[0] leaves it
        rdc(OFF_TOS_HIGH, 32'h1);
        apb(1'b1, OFF_TOS_HIGH, 32'h55);
        rdc(OFF_TOS_LOW, 32'hA5);
        pop_chk(15'h55A5);
        rdc(OFF_STACK_POINTER, 32'h2);
        rdc(12'h020, 32'h0);
        chk(32'(err), 32'h1);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, fault_en} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_call_return();
        t_wrap();
        t_fault_reset();
        t_tos_write();
        report_and_stop();
    end
endmodule // test_hardware_return_stack
`default_nettype wire
